// ==== core/oma_consts.svh ====
// Constants for the output cell array: register indices, field layout, reset values.
// Assumes inclusion by the package, the cell, the array, the checker and the bench.
`ifndef OMA_CONSTS_SVH
`define OMA_CONSTS_SVH
// ==========================================================
// Register indices in config io space (arbitrary placement)
`define OMA_REG_A_STATE 8'h20
`define OMA_REG_B_STATE 8'h21
`define OMA_REG_A_MASK 8'h22
`define OMA_REG_B_MASK 8'h23
`define OMA_REG_IN_A 8'h24
`define OMA_REG_IN_B 8'h25
`define OMA_REG_IN_C 8'h26
// ==========================================================
// Sizes and reset values
`define OMA_CELLS 16
`define OMA_GROUP 8
`define OMA_MASK_RESET 8'h00
`define OMA_STATE_RESET 8'h00
`define OMA_NATIVE_A 3
`define OMA_NATIVE_B 4
`define OMA_BORROW_A 6
`define OMA_BORROW_B_LO 5
`define OMA_BORROW_B_HI 6
`define OMA_MAX_TERMS 10
`define OMA_ARRAY_TERMS 137
`define OMA_SELECTS 3
// Per-cell configuration word layout
`define OMA_CFG_INVERT 0
`define OMA_CFG_REGSEL 1
`define OMA_CFG_TYPE_LO 2
`define OMA_CFG_CLKPIN 4
`endif

// ==== core/oma_pkg.sv ====
// Types for the output cell array.
// Assumes the constants header sits beside it.
`include "oma_consts.svh"
package oma_pkg;
	typedef enum logic [1:0] {
		OMA_FF_D = 2'b00,
		OMA_FF_T = 2'b01,
		OMA_FF_JK = 2'b11,
		OMA_FF_SR = 2'b10
	} oma_ff_e;
	// Configuration of one cell, fixed at build time by the fuse image
	typedef struct packed {
		logic clk_pin;
		oma_ff_e ff_type;
		logic reg_sel;
		logic invert;
	} oma_cfg_s;
	// Product terms presented to one cell after allocation
	typedef struct packed {
		logic [`OMA_MAX_TERMS-1:0] sum_terms;
		logic [`OMA_MAX_TERMS-1:0] aux_terms;
		logic clk_term;
		logic preset;
		logic [1:0] clear;
		logic oe_term;
	} oma_terms_s;
	// Host access carrier
	typedef struct packed {
		logic wr_n;
		logic rd_n;
		logic sel;
		logic [7:0] addr;
		logic [7:0] wdata;
	} oma_host_s;
endpackage

// ==== core/oma_cell.sv ====
// One output cell: polarity xor, configurable flip-flop, output select.
// Assumes core_clk domain; clock events arrive as one-cycle pulses.
`include "oma_consts.svh"
module oma_cell (
	input wire logic core_clk,
	input wire logic rst,
	input oma_pkg::oma_cfg_s cfg,
	input wire logic sum_in,
	input wire logic aux_in,
	input wire logic clk_event,
	input wire logic preset,
	input wire logic clear,
	input wire logic host_load,
	input wire logic host_bit,
	output logic cell_out,
	output logic ff_q
);
	import oma_pkg::*;
	logic fn;
	logic next_q;
	logic toggled;
	assign fn = sum_in ^ cfg.invert;
	assign toggled = ~ff_q;
	// ==========================================================
	// Flip-flop next state; sum is D/T/J/S, aux is K/R
	always_comb begin
		next_q = ff_q;
		if (host_load) begin
			next_q = host_bit;
		end else if (clear) begin
			next_q = 1'b0;
		end else if (preset) begin
			next_q = 1'b1;
		end else if (clk_event) begin
			case (cfg.ff_type)
				OMA_FF_D: next_q = fn;
				OMA_FF_T: next_q = fn ? toggled : ff_q;
				OMA_FF_JK: next_q = (fn & ~ff_q) | (~aux_in & ff_q);
				OMA_FF_SR: next_q = fn ? 1'b1 : (aux_in ? 1'b0 : ff_q);
				default: next_q = ff_q;
			endcase
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ff_q <= 1'b0;
		end else begin
			ff_q <= next_q;
		end
	end
	assign cell_out = cfg.reg_sel ? ff_q : fn;
endmodule

// ==== core/oma_array.sv ====
// Output cell array: sixteen cells, term allocation, host load and readback.
// Assumes host strobes and pins are asynchronous to core_clk; the AND array is outside.
`include "oma_consts.svh"
// How it works
// - Sixteen cells, eight per port
// - Xor stage sets each cell's polarity
// - Select register or combinational, feed back
// - Flip-flop acts as D, T, JK, SR
// - Clock from term or pin rising edge
// - Preset and clear active high, two-term clear
// - Native and borrowable term counts per group
// - Borrow only from fixed donors, exclusively
// - Expansion consumes cells, adds delay
// - Cell n sits on data bit n mod 8
// - Cells mapped in config io space
// - Host load overrides preset, clear, clock
// - Load captured on write strobe trailing edge
// - Host reads output and input cells
// - Per-group mask, resets to zero
// - Mask bit one blocks that cell
// - Three selects on fourth port, no cells
// - Up to 137 product terms
// - Pin enable is term or direction bit
module oma_array (
	input wire logic core_clk,
	input wire logic rst,
	input oma_pkg::oma_host_s host,
	output logic [7:0] rdata,
	output logic rdata_oe,
	input wire logic [`OMA_ARRAY_TERMS-1:0] pterms,
	input oma_pkg::oma_cfg_s [`OMA_CELLS-1:0] cell_cfg,
	input wire logic [`OMA_CELLS*`OMA_MAX_TERMS-1:0] term_route,
	input wire logic [`OMA_CELLS*8-1:0] term_index,
	input wire logic [`OMA_CELLS*8-1:0] clk_index,
	input wire logic [`OMA_CELLS*8-1:0] preset_index,
	input wire logic [`OMA_CELLS*16-1:0] clear_index,
	input wire logic [`OMA_CELLS*8-1:0] oe_index,
	input wire logic [`OMA_CELLS-1:0] dir_bits,
	input wire logic shared_clock_pin,
	input wire logic [23:0] input_cells,
	input wire logic [`OMA_SELECTS-1:0] select_terms,
	output logic [7:0] first_port_cells,
	output logic [7:0] second_port_cells,
	output logic [`OMA_CELLS-1:0] cell_oe,
	output logic [`OMA_CELLS-1:0] cell_feedback,
	output logic [`OMA_SELECTS-1:0] external_select_outputs
);
	import oma_pkg::*;
	// ==========================================================
	// Input synchronisers
	logic [2:0] wr_sync;
	logic [1:0] rd_sync;
	logic [1:0] sel_sync;
	logic [1:0] clk_sync;
	logic clk_prev;
	logic [7:0] addr_q;
	logic [7:0] wdata_q;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_sync <= 3'h7;
			rd_sync <= 2'h3;
			sel_sync <= 2'h0;
			clk_sync <= 2'h0;
			clk_prev <= 1'b0;
			addr_q <= 8'h00;
			wdata_q <= 8'h00;
		end else begin
			wr_sync <= {wr_sync[1:0], host.wr_n};
			rd_sync <= {rd_sync[0], host.rd_n};
			sel_sync <= {sel_sync[0], host.sel};
			clk_sync <= {clk_sync[0], shared_clock_pin};
			clk_prev <= clk_sync[1];
			// Address and data held stable by the host while strobe is low
			if (!wr_sync[1] || !rd_sync[1]) begin
				addr_q <= host.addr;
				wdata_q <= host.wdata;
			end
		end
	end
	// ==========================================================
	// Decode
	wire wr_trail = wr_sync[1] & ~wr_sync[2] & sel_sync[1];
	wire hit_a_state = addr_q == `OMA_REG_A_STATE;
	wire hit_b_state = addr_q == `OMA_REG_B_STATE;
	wire hit_a_mask = addr_q == `OMA_REG_A_MASK;
	wire hit_b_mask = addr_q == `OMA_REG_B_MASK;
	wire hit_in_a = addr_q == `OMA_REG_IN_A;
	wire hit_in_b = addr_q == `OMA_REG_IN_B;
	wire hit_in_c = addr_q == `OMA_REG_IN_C;
	wire pin_rise = clk_sync[1] & ~clk_prev;
	logic [7:0] mask_a;
	logic [7:0] mask_b;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mask_a <= `OMA_MASK_RESET;
			mask_b <= `OMA_MASK_RESET;
		end else begin
			if (wr_trail && hit_a_mask) begin
				mask_a <= wdata_q;
			end
			if (wr_trail && hit_b_mask) begin
				mask_b <= wdata_q;
			end
		end
	end
	// Per-cell load: mask bit one blocks only its own cell
	wire [`OMA_CELLS-1:0] load_en = {{8{wr_trail & hit_b_state}} & ~mask_b,
		{8{wr_trail & hit_a_state}} & ~mask_a};
	wire [`OMA_CELLS-1:0] load_bits = {wdata_q, wdata_q};
	// ==========================================================
	// Term allocation and cells
	logic [`OMA_CELLS-1:0] ff_q;
	logic [`OMA_CELLS-1:0] cell_out;
	logic [`OMA_CELLS-1:0] term_event;
	genvar gi;
	generate
		for (gi = 0; gi < `OMA_CELLS; gi++) begin : g_cell
			// Reachable terms: native plus borrowed; higher slots unusable
			localparam int REACH = (gi < 8) ? `OMA_NATIVE_A + `OMA_BORROW_A :
				((gi < 12) ? `OMA_NATIVE_B + `OMA_BORROW_B_LO : `OMA_NATIVE_B + `OMA_BORROW_B_HI);
			localparam int NATIVE = (gi < 8) ? `OMA_NATIVE_A : `OMA_NATIVE_B;
			localparam logic [`OMA_MAX_TERMS-1:0] REACH_MASK = `OMA_MAX_TERMS'((1 << REACH) - 1);
			localparam logic [`OMA_MAX_TERMS-1:0] NATIVE_MASK = `OMA_MAX_TERMS'((1 << NATIVE) - 1);
			wire [7:0] base = term_index[gi*8 +: 8];
			wire [`OMA_MAX_TERMS-1:0] route = term_route[gi*`OMA_MAX_TERMS +: `OMA_MAX_TERMS];
			logic [`OMA_MAX_TERMS-1:0] slots;
			logic [`OMA_MAX_TERMS-1:0] used;
			always_comb begin
				for (int k = 0; k < `OMA_MAX_TERMS; k++) begin
					slots[k] = pterms[8'(base + 8'(k)) % `OMA_ARRAY_TERMS];
				end
			end
			// Borrowed slots are granted only if the donor has not claimed them
			wire [`OMA_MAX_TERMS-1:0] donor_free = (gi == 0) ? ~route : ~term_route[(gi-1)*`OMA_MAX_TERMS +:
				`OMA_MAX_TERMS] | NATIVE_MASK;
			assign used = route & REACH_MASK & (NATIVE_MASK | donor_free);
			// Expansion terms from other consumed cells come in via feedback through the array
			wire sum_in = |(slots & used & ~{`OMA_MAX_TERMS{1'b0}} & NATIVE_MASK) | |(slots & used & ~NATIVE_MASK);
			wire aux_in = slots[NATIVE-1] & ~used[NATIVE-1];
			wire clk_term = pterms[clk_index[gi*8 +: 8] % `OMA_ARRAY_TERMS];
			wire pre = pterms[preset_index[gi*8 +: 8] % `OMA_ARRAY_TERMS];
			wire clr = pterms[clear_index[gi*16 +: 8] % `OMA_ARRAY_TERMS]
				| pterms[clear_index[gi*16+8 +: 8] % `OMA_ARRAY_TERMS];
			// One flop per cell keeps each bit single-driven
			logic term_prev;
			always_ff @(posedge core_clk) begin
				if (rst) begin
					term_prev <= 1'b0;
				end else begin
					term_prev <= clk_term;
				end
			end
			assign term_event[gi] = clk_term & ~term_prev;
			wire clk_ev = cell_cfg[gi].clk_pin ? pin_rise : term_event[gi];
			oma_cell u_cell (
				.core_clk(core_clk),
				.rst(rst),
				.cfg(cell_cfg[gi]),
				.sum_in(sum_in),
				.aux_in(aux_in),
				.clk_event(clk_ev),
				.preset(pre),
				.clear(clr),
				.host_load(load_en[gi]),
				.host_bit(load_bits[gi]),
				.cell_out(cell_out[gi]),
				.ff_q(ff_q[gi])
			);
			assign cell_oe[gi] = pterms[oe_index[gi*8 +: 8] % `OMA_ARRAY_TERMS] | dir_bits[gi];
		end
	endgenerate
	// ==========================================================
	// Pins and feedback registered as data outputs
	always_ff @(posedge core_clk) begin
		if (rst) begin
			first_port_cells <= `OMA_STATE_RESET;
			second_port_cells <= `OMA_STATE_RESET;
			cell_feedback <= 16'h0000;
			external_select_outputs <= 3'h0;
		end else begin
			first_port_cells <= cell_out[7:0];
			second_port_cells <= cell_out[15:8];
			cell_feedback <= cell_out;
			external_select_outputs <= select_terms;
		end
	end
	// ==========================================================
	// Readback
	wire rd_active = ~rd_sync[1] & sel_sync[1];
	wire [7:0] rd_mux = hit_a_state ? ff_q[7:0] :
		hit_b_state ? ff_q[15:8] :
		hit_a_mask ? mask_a :
		hit_b_mask ? mask_b :
		hit_in_a ? input_cells[7:0] :
		hit_in_b ? input_cells[15:8] :
		hit_in_c ? input_cells[23:16] : 8'h00;
	wire hit_any = hit_a_state | hit_b_state | hit_a_mask | hit_b_mask | hit_in_a | hit_in_b | hit_in_c;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd_mux;
		end
	end
	assign rdata_oe = rd_active & hit_any;
endmodule

// ==== tb/oma_array_chk.sv ====
// Checker for the output cell array, bound to its top module.
// Assumes one clock domain with a synchronous active high reset.
`include "oma_consts.svh"
module oma_array_chk import oma_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input oma_pkg::oma_host_s host,
	input wire logic rdata_oe,
	input wire logic [`OMA_ARRAY_TERMS-1:0] pterms,
	input wire logic [`OMA_CELLS*8-1:0] oe_index,
	input wire logic [`OMA_CELLS-1:0] dir_bits,
	input wire logic shared_clock_pin,
	input wire logic [`OMA_SELECTS-1:0] select_terms,
	input wire logic [7:0] first_port_cells,
	input wire logic [7:0] second_port_cells,
	input wire logic [`OMA_CELLS-1:0] cell_oe,
	input wire logic [`OMA_CELLS-1:0] cell_feedback,
	input wire logic [`OMA_SELECTS-1:0] external_select_outputs
);
	logic [`OMA_CELLS-1:0] oe_exp;
	for (genvar i = 0; i < `OMA_CELLS; i++) begin : g_oe
		assign oe_exp[i] = pterms[oe_index[i*8+:8] % `OMA_ARRAY_TERMS] | dir_bits[i];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Host strobe sequences
	sequence s_idle;
		(host.wr_n && !shared_clock_pin && $stable(pterms))[*8];
	endsequence
	sequence s_rd_bad;
		(!host.rd_n && host.sel && host.addr > `OMA_REG_IN_C)[*5];
	endsequence
	sequence s_rd_good;
		(!host.rd_n && host.sel && host.addr == `OMA_REG_A_STATE)[*5];
	endsequence
	chk_oe_formed: assert property (cell_oe == oe_exp)
		else $error("pin enable mismatch");
	chk_read_idle: assert property (host.rd_n[*5] |-> !rdata_oe)
		else $error("read data driven while idle");
	chk_read_unmapped: assert property (s_rd_bad |-> !rdata_oe)
		else $error("unmapped read drives data");
	chk_read_mapped: assert property (s_rd_good |-> rdata_oe)
		else $error("mapped read not driven");
	chk_cells_hold: assert property (s_idle |-> $stable({first_port_cells, second_port_cells}))
		else $error("cells changed without cause");
	chk_select_follow: assert property ($stable(select_terms)[*3] |-> external_select_outputs == select_terms)
		else $error("select outputs lag");
	chk_pin_feedback: assert property ($stable(cell_feedback)[*3]
		|-> {second_port_cells, first_port_cells} == cell_feedback)
		else $error("feedback differs from pins");
	chk_reset_clears: assert property (disable iff (1'b0) rst |=>
		first_port_cells == 8'h00 && second_port_cells == 8'h00 && external_select_outputs == 3'h0)
		else $error("outputs not cleared by reset");
endmodule
bind oma_array oma_array_chk u_chk (.core_clk(core_clk), .rst(rst), .host(host), .rdata_oe(rdata_oe),
	.pterms(pterms), .oe_index(oe_index), .dir_bits(dir_bits), .shared_clock_pin(shared_clock_pin),
	.select_terms(select_terms), .first_port_cells(first_port_cells), .second_port_cells(second_port_cells),
	.cell_oe(cell_oe), .cell_feedback(cell_feedback), .external_select_outputs(external_select_outputs));

// ==== tb/oma_host_bfm.sv ====
// Host processor model driving the array's strobe bus.
// Assumes callers wait for each access to return before the next.
module oma_host_bfm import oma_pkg::*; (
	input wire logic core_clk,
	output oma_pkg::oma_host_s host,
	input wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	int stretch = 0;
	initial host = '{wr_n: 1'b1, rd_n: 1'b1, sel: 1'b0, addr: 8'h00, wdata: 8'h00};
	// Strobe held low at least five edges so the synchroniser sees it
	task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge core_clk);
		host <= '{wr_n: rd, rd_n: !rd, sel: 1'b1, addr: a, wdata: d};
		repeat (5 + stretch) @(posedge core_clk);
		q = rdata;
		host.wr_n <= 1'b1;
		host.rd_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		host.sel <= 1'b0;
		host.wdata <= ~d;
	endtask
endmodule

// ==== tb/oma_array_test.sv ====
// Bench for the output cell array: loads, masks, readback, pin clock.
// Assumes the host model answers through u_host.
`include "oma_consts.svh"
module oma_array_test import oma_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam oma_cfg_s CFG_D = '{clk_pin: 1'b1, ff_type: OMA_FF_D, reg_sel: 1'b1, invert: 1'b0};
	localparam oma_cfg_s CFG_T = '{clk_pin: 1'b0, ff_type: OMA_FF_T, reg_sel: 1'b1, invert: 1'b1};
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	oma_host_s host;
	logic [7:0] rdata, fpc, spc;
	logic rdata_oe, clk_pin;
	logic [136:0] pterms;
	oma_cfg_s [15:0] cell_cfg;
	logic [159:0] term_route;
	logic [127:0] term_index, clk_index, preset_index, oe_index;
	logic [255:0] clear_index;
	logic [15:0] dir_bits, cell_oe, cell_feedback;
	logic [23:0] input_cells;
	logic [2:0] select_terms, ext_sel;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;
	always #2.5 core_clk = ~core_clk;
	oma_array u_oma_array (.core_clk(core_clk), .rst(rst), .host(host), .rdata(rdata), .rdata_oe(rdata_oe),
		.pterms(pterms), .cell_cfg(cell_cfg), .term_route(term_route), .term_index(term_index),
		.clk_index(clk_index), .preset_index(preset_index), .clear_index(clear_index), .oe_index(oe_index),
		.dir_bits(dir_bits), .shared_clock_pin(clk_pin), .input_cells(input_cells),
		.select_terms(select_terms), .first_port_cells(fpc), .second_port_cells(spc), .cell_oe(cell_oe),
		.cell_feedback(cell_feedback), .external_select_outputs(ext_sel));
	oma_host_bfm u_host (.core_clk(core_clk), .host(host), .rdata(rdata));
	// ==========================================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_host.access(1'b0, a, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		u_host.access(1'b1, a, 8'h00, q);
		check({8'h00, q}, {8'h00, exp});
	endtask
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			num_errors++;
			test_done();
		end
	end
	initial begin
		pterms = '0;
		cell_cfg = {16{CFG_D}};
		term_route = '0;
		term_index = {16{8'h04}};
		clk_index = {16{8'h03}};
		preset_index = {16{8'h01}};
		clear_index = {16{16'h0202}};
		oe_index = '0;
		dir_bits = '0;
		clk_pin = 1'b0;
		input_cells = 24'h96c35a;
		select_terms = 3'h0;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		rd_chk(`OMA_REG_A_MASK, 8'h00);
		rd_chk(`OMA_REG_B_MASK, 8'h00);
		$display("reset test done");
		wr(`OMA_REG_A_STATE, 8'ha5);
		wr(`OMA_REG_B_STATE, 8'h3c);
		rd_chk(`OMA_REG_A_STATE, 8'ha5);
		rd_chk(`OMA_REG_B_STATE, 8'h3c);
		check({8'h00, fpc}, 16'h00a5);
		check({8'h00, spc}, 16'h003c);
		$display("load test done");
		wr(`OMA_REG_A_MASK, 8'h0f);
		u_host.stretch = 4;
		wr(`OMA_REG_B_MASK, 8'hf0);
		rd_chk(`OMA_REG_A_MASK, 8'h0f);
		rd_chk(`OMA_REG_B_MASK, 8'hf0);
		wr(`OMA_REG_A_STATE, 8'hff);
		wr(`OMA_REG_B_STATE, 8'h00);
		rd_chk(`OMA_REG_A_STATE, 8'hf5);
		rd_chk(`OMA_REG_B_STATE, 8'h30);
		wr(`OMA_REG_A_MASK, 8'h00);
		wr(`OMA_REG_B_MASK, 8'h00);
		u_host.stretch = 0;
		$display("mask test done");
		for (int i = 0; i < 3; i++) begin
			rd_chk(8'(`OMA_REG_IN_A + i), input_cells[i*8+:8]);
		end
		rd_chk(8'h30, 8'h00);
		$display("readback test done");
		@(posedge core_clk);
		dir_bits <= 16'h00ff;
		repeat (2) @(posedge core_clk);
		check(cell_oe, 16'h00ff);
		pterms[0] <= 1'b1;
		repeat (2) @(posedge core_clk);
		check(cell_oe, 16'hffff);
		pterms[0] <= 1'b0;
		$display("enable test done");
		wr(`OMA_REG_A_STATE, 8'hff);
		clk_pin <= 1'b1;
		repeat (4) @(posedge core_clk);
		clk_pin <= 1'b0;
		repeat (6) @(posedge core_clk);
		check({spc, fpc}, 16'h0000);
		rd_chk(`OMA_REG_A_STATE, 8'h00);
		pterms[1] <= 1'b1;
		repeat (3) @(posedge core_clk);
		check({spc, fpc}, 16'hffff);
		pterms[2] <= 1'b1;
		repeat (3) @(posedge core_clk);
		check({spc, fpc}, 16'h0000);
		pterms[2:1] <= 2'b00;
		cell_cfg <= {16{CFG_T}};
		pterms[3] <= 1'b1;
		repeat (3) @(posedge core_clk);
		check({spc, fpc}, 16'hffff);
		pterms[3] <= 1'b0;
		repeat (2) @(posedge core_clk);
		pterms[3] <= 1'b1;
		repeat (3) @(posedge core_clk);
		check({spc, fpc}, 16'h0000);
		pterms[3] <= 1'b0;
		select_terms <= 3'b101;
		repeat (4) @(posedge core_clk);
		check({13'h0, ext_sel}, 16'h0005);
		$display("clock and select test done");
		test_done();
	end
endmodule
